/* File: verilog/apo_params.svh */
// Timing counts, codes and reset values for the parallel-output converter
`ifndef APO_PARAMS_SVH
`define APO_PARAMS_SVH

`define APO_CLK_PERIOD_NS 8
`define APO_CONV_TIME_NS 150
`define APO_CONV_CYCLES \
  ((`APO_CONV_TIME_NS + `APO_CLK_PERIOD_NS - 1) / `APO_CLK_PERIOD_NS)
`define APO_PIPE_DEPTH 2
`define APO_FIFO_DEPTH 8
`define APO_CODE_WIDTH 12
`define APO_LEVEL_WIDTH 16
`define APO_CODE_MIN 12'h800
`define APO_CODE_MAX 12'h7ff
`define APO_CODE_RESET 12'h000
`define APO_FLAG_RESET 1'h0
`define APO_PIN_RESET 1'h0
`define APO_GAIN_RESET 1'h1
`define APO_LEVEL_RESET 16'h0000

`endif

/* File: verilog/apo_pkg.sv */
// Types shared by the converter output logic
package apo_pkg;

  typedef struct packed {
    logic over_range;
    logic [11:0] code;
  } apo_result_t;

  typedef enum logic [0:0] {
    APO_IDLE,
    APO_CONVERT
  } apo_state_t;

endpackage : apo_pkg

/* File: verilog/apo_adc_core.sv */
// Conversion sequencer, sample FIFO and output pipeline of the converter
//
// Summary of operation
// - Rising conversion clock edge starts a sample.
// - Running conversion is never aborted nor restarted.
// - Output word updates 19 cycles (152 ns) after start.
// - Two-conversion pipeline before a sample appears.
// - Only rising edges of conversion clock matter.
// - Results are 12-bit two's complement always.
// - Over-range flag high on both end codes.
// - Zero is all zeros, minus one all ones.
`timescale 1ns/1ps
`include "apo_params.svh"

module apo_fifo #(
  parameter int W = 13,
  parameter int D = `APO_FIFO_DEPTH
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_in_valid, // Write request
  output logic o_in_ready, // Room for a word
  input wire logic [W-1:0] i_in_data, // Word written
  output logic o_out_valid, // Word available
  input wire logic i_out_ready, // Read request
  output logic [W-1:0] o_out_data // Oldest word
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(D);
  localparam logic [PW-1:0] LAST_C = PW'(D - 1);

  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign o_in_ready = (cnt_q != DEPTH_C);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d = (wr_q == LAST_C) ? '0 : wr_q + 1'h1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST_C) ? '0 : rd_q + 1'h1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'h1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < D; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : apo_fifo

// Two flip-flop synchroniser for a level that comes from outside
module apo_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic [W-1:0] i_pin, // Raw pin level
  output logic [W-1:0] o_sync // Level safe to use on this clock
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d;

  always_comb begin
    s1_d = i_pin;
    s2_d = s1_q;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= RST;
      s2_q <= RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // Only the second stage is read outside, the first may be metastable
  assign o_sync = s2_q;
endmodule : apo_sync

module apo_adc_core #(
  parameter int CONV_CYCLES = `APO_CONV_CYCLES,
  parameter int PIPE_DEPTH = `APO_PIPE_DEPTH
) (
  input wire logic i_sys_clk, // System clock, 125 MHz
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_conv_clk, // Conversion clock pin from host
  input wire logic i_gain_x1, // High selects unity input gain
  input wire logic [15:0] i_analog_level, // Signed input in steps
  output logic [11:0] o_result, // Two's complement result word
  output logic o_over_range_flag, // Result is at an end code
  output logic o_busy // Conversion running
);
  localparam int TW = $clog2(CONV_CYCLES + 1);
  localparam logic [TW-1:0] LOAD_C = TW'(CONV_CYCLES - 1);
  localparam int RW = $bits(apo_pkg::apo_result_t);

  // Every pin passes two flip-flops. The level bus must be held steady by
  // the source around the sampling edge, as a real sample-and-hold would
  // need, because its bits may resolve in different cycles.
  logic clk_sync, gain_sync;
  logic [15:0] lvl_sync;
  logic clk_last_q, clk_last_d;
  logic rise;

  apo_sync #(
    .W(1),
    .RST(`APO_PIN_RESET)
  ) u_clk_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_conv_clk),
    .o_sync(clk_sync)
  );

  apo_sync #(
    .W(1),
    .RST(`APO_GAIN_RESET)
  ) u_gain_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_gain_x1),
    .o_sync(gain_sync)
  );

  apo_sync #(
    .W(16),
    .RST(`APO_LEVEL_RESET)
  ) u_lvl_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_analog_level),
    .o_sync(lvl_sync)
  );

  // Pin level one cycle older; reset matches the idle low pin, so no
  // false edge follows reset
  always_comb begin
    clk_last_d = clk_sync;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_last_q <= `APO_PIN_RESET;
    end else begin
      clk_last_q <= clk_last_d;
    end
  end

  // Falling edges are ignored, so duty cycle is irrelevant
  assign rise = clk_sync && !clk_last_q;

  // Quantiser: clamp to the signed code range
  function automatic logic [11:0] quantise(input logic [15:0] lvl,
                                           input logic gain_x1);
    logic signed [16:0] v;
    v = gain_x1 ? 17'(signed'(lvl)) : 17'(signed'(lvl)) <<< 1;
    if (v > 17'sh007ff) begin
      quantise = `APO_CODE_MAX;
    end else if (v < -17'sh00800) begin
      quantise = `APO_CODE_MIN;
    end else begin
      // Zero maps to all zeros, minus one step to all ones at unity gain
      quantise = v[11:0];
    end
  endfunction : quantise

  apo_pkg::apo_state_t state_q, state_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic start, done;
  logic fifo_in_ready, fifo_out_valid;
  apo_pkg::apo_result_t fifo_in, fifo_out;
  logic [11:0] smp_code;
  logic smp_over;

  assign smp_code = quantise(lvl_sync, gain_sync);
  assign smp_over = (smp_code == `APO_CODE_MIN) ||
      (smp_code == `APO_CODE_MAX);
  assign fifo_in = '{over_range: smp_over, code: smp_code};

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    start = 1'h0;
    done = 1'h0;
    unique case (state_q)
      apo_pkg::APO_IDLE: begin
        // A full FIFO makes the rise be dropped, so that sample is lost
        if (rise && fifo_in_ready) begin
          start = 1'h1;
          state_d = apo_pkg::APO_CONVERT;
          tmr_d = LOAD_C;
        end
      end
      apo_pkg::APO_CONVERT: begin
        // Edges before the last conversion cycle are dropped; a rise in it starts the next one
        if (tmr_q == '0) begin
          done = 1'h1;
          if (rise && fifo_in_ready) begin
            start = 1'h1;
            tmr_d = LOAD_C;
          end else begin
            state_d = apo_pkg::APO_IDLE;
          end
        end else begin
          tmr_d = tmr_q - 1'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= apo_pkg::APO_IDLE;
      tmr_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
    end
  end

  // Sample taken at the start is held here until its conversion ends
  apo_fifo #(
    .W(RW),
    .D(`APO_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(start),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(done),
    .o_out_data(fifo_out)
  );

  // Pipeline stages advance once per finished conversion, so a sample
  // reaches the pins at the end of the conversion two starts later.
  apo_pkg::apo_result_t pipe_q [PIPE_DEPTH];
  apo_pkg::apo_result_t pipe_d [PIPE_DEPTH];
  apo_pkg::apo_result_t out_q, out_d;

  always_comb begin
    pipe_d = pipe_q;
    out_d = out_q;
    if (done && fifo_out_valid) begin
      out_d = pipe_q[PIPE_DEPTH-1];
      for (int i = PIPE_DEPTH - 1; i > 0; i--) begin
        pipe_d[i] = pipe_q[i-1];
      end
      pipe_d[0] = fifo_out;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= '{over_range: `APO_FLAG_RESET,
                       code: `APO_CODE_RESET};
      end
      out_q <= '{over_range: `APO_FLAG_RESET, code: `APO_CODE_RESET};
    end else begin
      pipe_q <= pipe_d;
      out_q <= out_d;
    end
  end

  // Flag and code leave one register, so they can never be skewed
  assign o_result = out_q.code;
  assign o_over_range_flag = out_q.over_range;
  assign o_busy = (state_q == apo_pkg::APO_CONVERT);
endmodule : apo_adc_core

/* File: test/apo_chk.sv */
// Assertions on the converter output ports
`timescale 1ns/1ps
module apo_chk #(
  parameter int CONV_CYCLES = 19
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_conv_clk, // Conversion pin
  input wire logic [11:0] o_result, // Result
  input wire logic o_over_range_flag, // Flag
  input wire logic o_busy // Busy
);
  logic [11:0] last_q, last_d;
  logic [7:0] gap_q, gap_d;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Cycles since the word last moved, saturating
  always_comb begin
    last_d = o_result;
    gap_d = (o_result != last_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      last_q <= 12'h000;
      gap_q <= 8'h00;
    end else begin
      last_q <= last_d;
      gap_q <= gap_d;
    end
  end
  a_flag_codes: assert property (o_over_range_flag ==
    (o_result == 12'h800 || o_result == 12'h7ff)) else $error("bad flag");
  a_flag_pair: assert property ($changed(o_over_range_flag) |->
    $changed(o_result)) else $error("flag moved alone");
  a_update_gap: assert property (o_result != last_q |->
    gap_q >= CONV_CYCLES - 1) else $error("word moved too soon");
  a_update_busy: assert property ($changed(o_result) |->
    $past(o_busy)) else $error("word moved without conversion");
  a_idle_hold: assert property (!o_busy && !$past(o_busy) |->
    $stable(o_result)) else $error("word moved while idle");
  a_start_rise: assert property ($rose(i_conv_clk) && !o_busy |->
    ##[2:4] $rose(o_busy)) else $error("rise did not start");
  a_busy_cause: assert property ($rose(o_busy) |->
    $past(i_conv_clk, 3) || $past(i_conv_clk, 4)) else $error("no rise");
  a_busy_length: assert property ($rose(o_busy) |->
    o_busy[*8] ##1 o_busy[*8] ##1 o_busy[*3]) else $error("aborted");
  c_flag: cover property ($rose(o_over_range_flag));
  c_busy: cover property ($rose(o_busy));
  c_word: cover property ($changed(o_result));
endmodule : apo_chk

bind apo_adc_core apo_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_conv_clk(i_conv_clk),
  .o_result(o_result), .o_over_range_flag(o_over_range_flag),
  .o_busy(o_busy));

/* File: test/apo_host.sv */
// Host model: clocks conversions and latches each result word
`timescale 1ns/1ps
module apo_host (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic [7:0] i_period, // Cycles per conversion
  input wire logic [7:0] i_high, // Cycles the pin stays high
  input wire apo_pkg::apo_result_t i_word, // Converter output
  output logic o_conv_clk, // Conversion clock pin
  output logic o_rise, // First cycle of pin high
  output logic o_got, // Word latched
  output apo_pkg::apo_result_t o_word, // Latched word
  output logic [11:0] o_offset // Offset binary view
);
  logic [7:0] cnt_q;
  logic [1:0] n_q;
  // Pin stays low outside the high phase, whatever the duty
  assign o_conv_clk = cnt_q < i_high;
  assign o_rise = cnt_q == 8'h00;
  assign o_offset = {~o_word.code[11], o_word.code[10:0]};
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'hff;
      n_q <= 2'h0;
      o_got <= 1'h0;
      o_word <= '0;
    end else begin
      o_got <= 1'h0;
      if (cnt_q >= i_period - 8'h01) begin
        cnt_q <= 8'h00;
        if (n_q == 2'h3) begin
          o_got <= 1'h1;
          o_word <= i_word;
        end else begin
          n_q <= n_q + 2'h1;
        end
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : apo_host

/* File: test/tb_apo_adc_core.sv */
// Self-checking bench for the converter output logic
`timescale 1ns/1ps
module tb_apo_adc_core;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic gain = 1'h1;
  logic [15:0] lvl = 16'h0000;
  logic [7:0] per = 8'h19;
  logic [7:0] hi = 8'h0c;
  logic conv, rise, got, ovr, busy;
  logic [11:0] res, off;
  apo_pkg::apo_result_t word, e;
  apo_pkg::apo_result_t q[$];
  int mismatches = 0;
  int n_tests = 0;
  logic [15:0] tbl [8] = '{16'h0000, 16'hffff, 16'h07ff, 16'hf800,
    16'h0800, 16'hf7ff, 16'h0400, 16'h03ff};
  initial forever #4 clk = ~clk;
  apo_adc_core uut (.i_sys_clk(clk), .i_rst(rst), .i_conv_clk(conv),
    .i_gain_x1(gain), .i_analog_level(lvl), .o_result(res),
    .o_over_range_flag(ovr), .o_busy(busy));
  apo_host host (.i_sys_clk(clk), .i_rst(rst), .i_period(per),
    .i_high(hi), .i_word({ovr, res}), .o_conv_clk(conv), .o_rise(rise),
    .o_got(got), .o_word(word), .o_offset(off));
  function automatic apo_pkg::apo_result_t exp_of(logic [15:0] v, logic g);
    logic signed [17:0] s;
    s = {{2{v[15]}}, v};
    if (!g) s = s <<< 1;
    if (s > 18'sh007ff) s = 18'sh007ff;
    if (s < -18'sh00800) s = -18'sh00800;
    exp_of.code = s[11:0];
    exp_of.over_range = s[11:0] == 12'h800 || s[11:0] == 12'h7ff;
  endfunction : exp_of
  task automatic final_report;
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // Level is changed well away from the sampling rise
  task automatic smp(logic [15:0] v, logic g);
    int i;
    lvl = v;
    gain = g;
    q.push_back(exp_of(v, g));
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (rise !== 1'h1 && i < 100);
    if (rise !== 1'h1) begin
      mismatches++;
      $display("mismatch rise expected 1 seen %b", rise);
      final_report();
    end
    repeat (8) @(posedge clk);
    #1;
  endtask : smp
  always @(posedge clk) begin
    if (got === 1'h1) begin
      n_tests++;
      e = (q.size() > 0) ? q.pop_front() : 'x;
      if (word !== e) begin
        mismatches++;
        $display("mismatch word expected %h seen %h", e, word);
      end
      if (off !== {~e.code[11], e.code[10:0]}) begin
        mismatches++;
        $display("mismatch offset expected %h seen %h",
          {~e.code[11], e.code[10:0]}, off);
      end
    end
  end
  initial begin
    void'($urandom(32'h73556574));
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < 16; k++) smp(tbl[k / 2], k[0]);
    // Shortest period that still meets the third-edge latch
    per = 8'h17;
    hi = 8'h01;
    for (int k = 0; k < 24; k++) smp(16'(int'($urandom % 5000) - 2500),
      1'($urandom));
    // The last sample is latched three host edges after its own
    for (int t = 0; t < 200 && q.size() > 0; t++) @(posedge clk);
    if (q.size() > 0) begin
      mismatches++;
      $display("mismatch queue expected 0 seen %0d", q.size());
    end
    final_report();
  end
endmodule : tb_apo_adc_core
